// *** common/stf_defines.svh ***
// Constants for the status transition filter bank
// Notes on behaviour
// - Operation rise sets settle bit B1 at start
// - Operation rise sets B5 entering trigger wait
// - Operation rise sets B6 entering arm wait
// - Operation rise sets B10 entering idle
// - Trigger rise sets sequence-one B1 in trigger
// - Arm rise sets sequence-one B1 in arm
// - Sequence rise sets B1 layer one, B2 two
// - Enabled falling edge latches matching event bit
// - Operation fall sets settle bit B1 at end
// - Operation fall sets B5 leaving trigger layer
// - Operation fall sets B6 leaving arm layer
// - Operation fall sets B10 leaving idle
// - Rise mask one enables, zero disables
// - Fall mask one enables, zero disables
// - Operation masks use only B10, B6, B5, B1
// - Four separate fall masks, own write paths
// - Fall masks clear at power-up and preset
// - Query returns mask bits as binary value
// - Sequence masks use only B2 and B1
// - Enabled rising edge latches matching event bit
// - Trigger fall sets sequence-one leaving trigger
// - Arm fall sets sequence-one leaving arm
`ifndef STF_DEFINES_SVH
`define STF_DEFINES_SVH
`define STF_W            16
`define STF_NF           4
`define STF_OPER_VALID   16'h0462
`define STF_TRIG_VALID   16'h0002
`define STF_ARM_VALID    16'h0002
`define STF_SEQ_VALID    16'h0006
`define STF_RISE_RST     16'hFFFF
`define STF_FALL_RST     16'h0000
`define STF_EVT_RST      16'h0000
`define STF_B_SETTLE     1
`define STF_B_TRIG_LAYER 5
`define STF_B_ARM_LAYER  6
`define STF_B_IDLE       10
`define STF_B_SEQ_ONE    1
`define STF_B_LAYER_ONE  1
`define STF_B_LAYER_TWO  2
`endif

// *** common/stf_pkg.sv ***
// Types for the status transition filter bank
package stf_pkg;
`include "stf_defines.svh"
   typedef enum logic [1:0] {STF_OPER, STF_TRIG, STF_ARM, STF_SEQ} stf_filt_t;
   typedef enum logic [2:0]
   {
      STF_OP_NONE, STF_OP_WRITE, STF_OP_QUERY, STF_OP_PRESET, STF_OP_CLS
   } stf_op_t;
   typedef struct packed
   {
      stf_op_t              op;
      stf_filt_t            filt;
      logic                 fall;
      logic [`STF_W-1:0]    data;
   } stf_cmd_t;
   typedef struct packed
   {
      logic                 valid;
      logic [`STF_W-1:0]    data;
   } stf_rsp_t;
   typedef logic [`STF_NF-1:0][`STF_W-1:0] stf_word4_t;
endpackage

// *** logic/stf_filter.sv ***
// Four-way rising/falling transition filter with mask registers
`timescale 1ns/1ps
`include "stf_defines.svh"
module stf_filter
   import stf_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire stf_cmd_t   cmd,
   input  wire stf_word4_t cond,
   input  wire stf_word4_t evt_clr,
   output stf_word4_t      evt,
   output stf_rsp_t        rsp
);

   // Writable bits per filter, index order oper, trig, arm, seq
   wire stf_word4_t valid_w;
   assign valid_w = {`STF_SEQ_VALID, `STF_ARM_VALID,
                     `STF_TRIG_VALID, `STF_OPER_VALID};

   stf_word4_t rise_r;
   stf_word4_t fall_r;
   stf_word4_t prev_r;
   stf_word4_t evt_r;
   stf_rsp_t   rsp_r;
   logic       primed_r;

   stf_word4_t rise_nxt;
   stf_word4_t fall_nxt;
   stf_word4_t set_w;
   stf_word4_t evt_nxt;
   stf_rsp_t   rsp_nxt;

   wire        is_write;
   wire        is_query;
   wire        is_preset;
   wire [`STF_W-1:0] q_mask;

   assign is_write  = (cmd.op == STF_OP_WRITE);
   assign is_query  = (cmd.op == STF_OP_QUERY);
   assign is_preset = (cmd.op == STF_OP_PRESET);

   // Clear-status command is accepted and touches nothing here
   assign q_mask = cmd.fall ? fall_r[cmd.filt] : rise_r[cmd.filt];

   assign rsp_nxt.valid = is_query;
   assign rsp_nxt.data  = is_query ? q_mask : rsp_r.data;

   genvar i;
   generate
      for (i = 0; i < `STF_NF; i++)
      begin : g_filt
         wire                  hit_w;
         wire [`STF_W-1:0]     rise_up_w;
         wire [`STF_W-1:0]     fall_dn_w;
         assign hit_w = is_write && (cmd.filt == stf_filt_t'(i));

         // Summed-weight value lands bit for bit; unused bits drop
         assign rise_nxt[i] = is_preset ? (`STF_RISE_RST & valid_w[i])
                            : (hit_w && !cmd.fall) ? (cmd.data & valid_w[i])
                            : rise_r[i];
         assign fall_nxt[i] = is_preset ? `STF_FALL_RST
                            : (hit_w && cmd.fall) ? (cmd.data & valid_w[i])
                            : fall_r[i];

         // Zero-to-one and one-to-zero changes of each condition bit
         assign rise_up_w = cond[i] & ~prev_r[i] & rise_r[i];
         assign fall_dn_w = ~cond[i] & prev_r[i] & fall_r[i];
         assign set_w[i]  = {`STF_W{primed_r}}
                          & (rise_up_w | fall_dn_w)
                          & valid_w[i];

         // New edges win over a clear in the same cycle
         assign evt_nxt[i] = (evt_r[i] & ~evt_clr[i]) | set_w[i];

         always_ff @(posedge ref_clk)
         begin
            if (!rst_n)
            begin
               rise_r[i] <= `STF_RISE_RST & valid_w[i];
               fall_r[i] <= `STF_FALL_RST;
               prev_r[i] <= `STF_EVT_RST;
               evt_r[i]  <= `STF_EVT_RST;
            end
            else if (ce)
            begin
               rise_r[i] <= rise_nxt[i];
               fall_r[i] <= fall_nxt[i];
               prev_r[i] <= cond[i];
               evt_r[i]  <= evt_nxt[i];
            end
         end
      end
   endgenerate

   // First sample only seeds the history, so no false edge at start
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         primed_r <= 1'b0;
         rsp_r    <= '0;
      end
      else if (ce)
      begin
         primed_r <= 1'b1;
         rsp_r    <= rsp_nxt;
      end
   end

   assign evt = evt_r;
   assign rsp = rsp_r;

   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   property p_oper_settle_rise;
      ce && primed_r && rise_r[STF_OPER][`STF_B_SETTLE]
      && cond[STF_OPER][`STF_B_SETTLE] && !prev_r[STF_OPER][`STF_B_SETTLE]
      |=> evt_r[STF_OPER][`STF_B_SETTLE];
   endproperty
   a_oper_settle_rise: assert property (p_oper_settle_rise)
      else $error("settle rise not latched");

   property p_oper_trig_rise;
      ce && primed_r && rise_r[STF_OPER][`STF_B_TRIG_LAYER]
      && $rose(cond[STF_OPER][`STF_B_TRIG_LAYER])
      && prev_r[STF_OPER][`STF_B_TRIG_LAYER] == 1'b0
      |=> evt_r[STF_OPER][`STF_B_TRIG_LAYER];
   endproperty
   a_oper_trig_rise: assert property (p_oper_trig_rise)
      else $error("trigger layer rise not latched");

   property p_oper_arm_rise;
      ce && primed_r && rise_r[STF_OPER][`STF_B_ARM_LAYER]
      && cond[STF_OPER][`STF_B_ARM_LAYER] && !prev_r[STF_OPER][`STF_B_ARM_LAYER]
      |=> evt_r[STF_OPER][`STF_B_ARM_LAYER];
   endproperty
   a_oper_arm_rise: assert property (p_oper_arm_rise)
      else $error("arm layer rise not latched");

   property p_oper_idle_rise;
      ce && primed_r && rise_r[STF_OPER][`STF_B_IDLE]
      && cond[STF_OPER][`STF_B_IDLE] && !prev_r[STF_OPER][`STF_B_IDLE]
      |=> evt_r[STF_OPER][`STF_B_IDLE];
   endproperty
   a_oper_idle_rise: assert property (p_oper_idle_rise)
      else $error("idle rise not latched");

   property p_trig_seq_rise;
      ce && primed_r && rise_r[STF_TRIG][`STF_B_SEQ_ONE]
      && cond[STF_TRIG][`STF_B_SEQ_ONE] && !prev_r[STF_TRIG][`STF_B_SEQ_ONE]
      |=> evt_r[STF_TRIG][`STF_B_SEQ_ONE];
   endproperty
   a_trig_seq_rise: assert property (p_trig_seq_rise)
      else $error("trigger sequence-one rise not latched");

   property p_arm_seq_rise;
      ce && primed_r && rise_r[STF_ARM][`STF_B_SEQ_ONE]
      && cond[STF_ARM][`STF_B_SEQ_ONE] && !prev_r[STF_ARM][`STF_B_SEQ_ONE]
      |=> evt_r[STF_ARM][`STF_B_SEQ_ONE];
   endproperty
   a_arm_seq_rise: assert property (p_arm_seq_rise)
      else $error("arm sequence-one rise not latched");

   property p_seq_layer_rise;
      ce && primed_r && rise_r[STF_SEQ][`STF_B_LAYER_TWO]
      && cond[STF_SEQ][`STF_B_LAYER_TWO] && !prev_r[STF_SEQ][`STF_B_LAYER_TWO]
      |=> evt_r[STF_SEQ][`STF_B_LAYER_TWO];
   endproperty
   a_seq_layer_rise: assert property (p_seq_layer_rise)
      else $error("layer two rise not latched");

   property p_oper_settle_fall;
      ce && primed_r && fall_r[STF_OPER][`STF_B_SETTLE]
      && !cond[STF_OPER][`STF_B_SETTLE] && prev_r[STF_OPER][`STF_B_SETTLE]
      |=> evt_r[STF_OPER][`STF_B_SETTLE];
   endproperty
   a_oper_settle_fall: assert property (p_oper_settle_fall)
      else $error("settle fall not latched");

   property p_oper_trig_fall;
      ce && primed_r && fall_r[STF_OPER][`STF_B_TRIG_LAYER]
      && !cond[STF_OPER][`STF_B_TRIG_LAYER] && prev_r[STF_OPER][`STF_B_TRIG_LAYER]
      |=> evt_r[STF_OPER][`STF_B_TRIG_LAYER];
   endproperty
   a_oper_trig_fall: assert property (p_oper_trig_fall)
      else $error("trigger layer fall not latched");

   property p_oper_arm_fall;
      ce && primed_r && fall_r[STF_OPER][`STF_B_ARM_LAYER]
      && !cond[STF_OPER][`STF_B_ARM_LAYER] && prev_r[STF_OPER][`STF_B_ARM_LAYER]
      |=> evt_r[STF_OPER][`STF_B_ARM_LAYER];
   endproperty
   a_oper_arm_fall: assert property (p_oper_arm_fall)
      else $error("arm layer fall not latched");

   property p_oper_idle_fall;
      ce && primed_r && fall_r[STF_OPER][`STF_B_IDLE]
      && !cond[STF_OPER][`STF_B_IDLE] && prev_r[STF_OPER][`STF_B_IDLE]
      |=> evt_r[STF_OPER][`STF_B_IDLE];
   endproperty
   a_oper_idle_fall: assert property (p_oper_idle_fall)
      else $error("idle fall not latched");

   property p_trig_seq_fall;
      ce && primed_r && fall_r[STF_TRIG][`STF_B_SEQ_ONE]
      && !cond[STF_TRIG][`STF_B_SEQ_ONE] && prev_r[STF_TRIG][`STF_B_SEQ_ONE]
      |=> evt_r[STF_TRIG][`STF_B_SEQ_ONE];
   endproperty
   a_trig_seq_fall: assert property (p_trig_seq_fall)
      else $error("trigger sequence-one fall not latched");

   property p_arm_seq_fall;
      ce && primed_r && fall_r[STF_ARM][`STF_B_SEQ_ONE]
      && !cond[STF_ARM][`STF_B_SEQ_ONE] && prev_r[STF_ARM][`STF_B_SEQ_ONE]
      |=> evt_r[STF_ARM][`STF_B_SEQ_ONE];
   endproperty
   a_arm_seq_fall: assert property (p_arm_seq_fall)
      else $error("arm sequence-one fall not latched");

   property p_mask_off_blocks;
      ce && !rise_r[STF_SEQ][`STF_B_LAYER_ONE] && !evt_r[STF_SEQ][`STF_B_LAYER_ONE]
      && cond[STF_SEQ][`STF_B_LAYER_ONE] && !prev_r[STF_SEQ][`STF_B_LAYER_ONE]
      |=> !evt_r[STF_SEQ][`STF_B_LAYER_ONE];
   endproperty
   a_mask_off_blocks: assert property (p_mask_off_blocks)
      else $error("disabled rise still latched");

   property p_fall_off_blocks;
      ce && !fall_r[STF_OPER][`STF_B_IDLE] && !evt_r[STF_OPER][`STF_B_IDLE]
      && !cond[STF_OPER][`STF_B_IDLE] && prev_r[STF_OPER][`STF_B_IDLE]
      |=> !evt_r[STF_OPER][`STF_B_IDLE];
   endproperty
   a_fall_off_blocks: assert property (p_fall_off_blocks)
      else $error("disabled fall still latched");

   property p_unused_zero;
      ((rise_r[STF_OPER] | fall_r[STF_OPER]) & ~`STF_OPER_VALID) == `STF_EVT_RST
      && ((rise_r[STF_SEQ] | fall_r[STF_SEQ]) & ~`STF_SEQ_VALID) == `STF_EVT_RST;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused mask bit set");

   property p_preset_clears;
      ce && is_preset |=> fall_r == '0 ##1 (!ce || fall_r == '0 || $past(is_write));
   endproperty
   a_preset_clears: assert property (p_preset_clears)
      else $error("preset left fall mask set");

   property p_cls_keeps;
      ce && cmd.op == STF_OP_CLS |=> $stable(fall_r) && $stable(rise_r);
   endproperty
   a_cls_keeps: assert property (p_cls_keeps)
      else $error("clear-status changed a mask");

   property p_query_answer;
      ce && is_query |=> rsp_r.valid && rsp_r.data == $past(q_mask);
   endproperty
   a_query_answer: assert property (p_query_answer)
      else $error("query answer wrong");

   property p_write_own_path;
      ce && is_write && cmd.fall && cmd.filt == STF_ARM
      |=> fall_r[STF_ARM] == ($past(cmd.data) & `STF_ARM_VALID)
          && $stable(fall_r[STF_OPER]) && $stable(fall_r[STF_SEQ]);
   endproperty
   a_write_own_path: assert property (p_write_own_path)
      else $error("fall write reached wrong filter");

   property p_event_holds;
      ce && evt_r[STF_OPER][`STF_B_IDLE] && !evt_clr[STF_OPER][`STF_B_IDLE]
      |=> evt_r[STF_OPER][`STF_B_IDLE] [*1];
   endproperty
   a_event_holds: assert property (p_event_holds)
      else $error("latched event dropped");

   property p_seq_layer_one_rise;
      ce && primed_r && rise_r[STF_SEQ][`STF_B_LAYER_ONE]
      && cond[STF_SEQ][`STF_B_LAYER_ONE] && !prev_r[STF_SEQ][`STF_B_LAYER_ONE]
      |=> evt_r[STF_SEQ][`STF_B_LAYER_ONE];
   endproperty
   a_seq_layer_one_rise: assert property (p_seq_layer_one_rise)
      else $error("layer one rise not latched");

   property p_seq_layer_fall;
      ce && primed_r && fall_r[STF_SEQ][`STF_B_LAYER_TWO]
      && !cond[STF_SEQ][`STF_B_LAYER_TWO] && prev_r[STF_SEQ][`STF_B_LAYER_TWO]
      |=> evt_r[STF_SEQ][`STF_B_LAYER_TWO];
   endproperty
   a_seq_layer_fall: assert property (p_seq_layer_fall)
      else $error("layer two fall not latched");

   property p_rise_write;
      ce && is_write && !cmd.fall && cmd.filt == STF_OPER
      |=> rise_r[STF_OPER] == ($past(cmd.data) & `STF_OPER_VALID)
          && $stable(rise_r[STF_TRIG]) && $stable(fall_r[STF_OPER]);
   endproperty
   a_rise_write: assert property (p_rise_write)
      else $error("rise mask write wrong");

   property p_fall_write_trig;
      ce && is_write && cmd.fall && cmd.filt == STF_TRIG
      |=> fall_r[STF_TRIG] == ($past(cmd.data) & `STF_TRIG_VALID)
          && $stable(fall_r[STF_ARM]) && $stable(rise_r[STF_TRIG]);
   endproperty
   a_fall_write_trig: assert property (p_fall_write_trig)
      else $error("trigger fall write wrong");

   property p_preset_rise;
      ce && is_preset |=> rise_r == valid_w && fall_r == '0;
   endproperty
   a_preset_rise: assert property (p_preset_rise)
      else $error("preset left masks wrong");

   property p_query_pulse;
      ce && !is_query |=> !rsp_r.valid;
   endproperty
   a_query_pulse: assert property (p_query_pulse)
      else $error("query answer flag stuck");

   property p_evt_only_valid;
      (evt_r & ~valid_w) == '0;
   endproperty
   a_evt_only_valid: assert property (p_evt_only_valid)
      else $error("event outside writable bits");

   property p_no_false_start;
      ce && !primed_r |=> evt_r == ($past(evt_r) & ~$past(evt_clr));
   endproperty
   a_no_false_start: assert property (p_no_false_start)
      else $error("false edge after reset");

   property p_set_beats_clear;
      ce && set_w[STF_ARM][`STF_B_SEQ_ONE] && evt_clr[STF_ARM][`STF_B_SEQ_ONE]
      |=> evt_r[STF_ARM][`STF_B_SEQ_ONE];
   endproperty
   a_set_beats_clear: assert property (p_set_beats_clear)
      else $error("clear beat a new edge");

   c_oper_trig_rise: cover property (ce && set_w[STF_OPER][`STF_B_TRIG_LAYER]);
   c_seq_fall:       cover property (ce && set_w[STF_SEQ][`STF_B_LAYER_TWO]);
   c_preset:         cover property (ce && is_preset);
   c_query:          cover property (ce && is_query ##1 rsp_r.valid);

endmodule // stf_filter

// *** testbench/status_transition_filter_tb.sv ***
// Self-checking bench for the transition filter bank
`timescale 1ns/1ps
`include "stf_defines.svh"
module status_transition_filter_tb
   import stf_pkg::*;
;
   logic       ref_clk;
   logic       rst_n;
   logic       ce;
   stf_cmd_t   cmd;
   stf_rsp_t   rsp;
   stf_word4_t cond, evt_clr, evt, evt_exp, prev, rm, fm;
   stf_word4_t vm = {`STF_SEQ_VALID, `STF_ARM_VALID, `STF_TRIG_VALID, `STF_OPER_VALID};
   int         n_mismatch, total_checks;
   logic [15:0] q;
   logic       ok;

   stf_filter dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .cmd(cmd), .cond(cond),
                     .evt_clr(evt_clr), .evt(evt), .rsp(rsp));
   stf_host host_u (.ref_clk(ref_clk), .rsp(rsp), .cmd(cmd));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wr(input int f, input logic fl, input logic [15:0] d);
      host_u.send(STF_OP_WRITE, stf_filt_t'(f), fl, d, q, ok);
      if (fl)
         fm[f] = d & vm[f];
      else
         rm[f] = d & vm[f];
   endtask

   task automatic rd(input int f, input logic fl, input logic [15:0] e);
      host_u.send(STF_OP_QUERY, stf_filt_t'(f), fl, 16'h0000, q, ok);
      check(64'(ok), 64'(1'b1));
      if (!ok)
         complete_run;
      else
      begin
         check(64'(q), 64'(e));
         check(64'({rsp.valid, rsp.data}), 64'({1'b0, e}));
      end
   endtask

   task automatic rd_all;
      for (int f = 0; f < 4; f++)
      begin
         rd(f, 1'b0, rm[f]);
         rd(f, 1'b1, fm[f]);
      end
   endtask

   // One cycle of the event model; rnd picks fresh condition traffic
   task automatic step(input logic rnd);
      @(posedge ref_clk);
      if (ce)
      begin
         for (int f = 0; f < 4; f++)
            evt_exp[f] = (evt_exp[f] & ~evt_clr[f]) | (rm[f] & ~prev[f] & cond[f])
                       | (fm[f] & prev[f] & ~cond[f]);
         prev = cond;
      end
      #5;
      check(64'(evt[0]), 64'(evt_exp[0]));
      check(64'(evt[1]), 64'(evt_exp[1]));
      check(64'(evt[2]), 64'(evt_exp[2]));
      check(64'(evt[3]), 64'(evt_exp[3]));
      ce = rnd ? ($urandom_range(7) != 0) : 1'b1;
      evt_clr = rnd ? {$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom} : '0;
      if (rnd)
         cond = {$urandom, $urandom};
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   initial
   begin
      rst_n = 1'b0;
      ce = 1'b1;
      cond = '0;
      evt_clr = '0;
      prev = '0;
      evt_exp = '0;
      rm = vm;
      fm = '0;
      n_mismatch = 0;
      total_checks = 0;
      void'($urandom(81724));
      repeat (20) @(posedge ref_clk);
      #5 rst_n = 1'b1;
      rd_all;
      $display("test reset_values done");
      wr(0, 1'b1, 16'h0402);
      rd(0, 1'b1, 16'h0402);
      wr(0, 1'b1, 16'h0000);
      rd(0, 1'b1, 16'h0000);
      repeat (6)
         for (int f = 0; f < 4; f++)
            for (int fl = 0; fl < 2; fl++)
            begin
               wr(f, fl[0], 16'($urandom));
               rd(f, fl[0], fl ? fm[f] : rm[f]);
            end
      $display("test mask_access done");
      repeat (6)
      begin
         for (int f = 0; f < 4; f++)
         begin
            wr(f, 1'b0, 16'($urandom));
            wr(f, 1'b1, 16'($urandom));
         end
         repeat (60) step(1'b1);
         step(1'b0);
      end
      $display("test edge_filter done");
      wr(2, 1'b1, 16'h0002);
      host_u.send(STF_OP_CLS, STF_OPER, 1'b0, 16'h0000, q, ok);
      check(evt, evt_exp);
      rd_all;
      host_u.send(STF_OP_PRESET, STF_OPER, 1'b0, 16'h0000, q, ok);
      rm = vm;
      fm = '0;
      rd_all;
      repeat (40) step(1'b1);
      step(1'b0);
      $display("test preset_clear done");
      wr(0, 1'b1, 16'h0462);
      wr(3, 1'b1, 16'h0006);
      rst_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #5 rst_n = 1'b1;
      rm = vm;
      fm = '0;
      evt_exp = '0;
      prev = cond;
      check(evt, evt_exp);
      rd_all;
      repeat (20) step(1'b1);
      step(1'b0);
      $display("test reset_mid done");
      complete_run;
   end
endmodule // status_transition_filter_tb

// *** testbench/stf_host.sv ***
// Behavioural remote host issuing mask commands
`timescale 1ns/1ps
module stf_host
   import stf_pkg::*;
(
   input  wire logic     ref_clk,
   input  wire stf_rsp_t rsp,
   output stf_cmd_t      cmd
);
   initial cmd = '{STF_OP_NONE, STF_OPER, 1'b0, 16'h0000};
   // One command after a random idle gap; always leaves one idle cycle
   task automatic send(input stf_op_t op, input stf_filt_t f, input logic fl,
                       input logic [15:0] d, output logic [15:0] q, output logic ok);
      int k;
      k = 0;
      q = 16'h0000;
      repeat ($urandom_range(2))
      begin
         @(posedge ref_clk);
         #5;
      end
      cmd = '{op, f, fl, d};
      @(posedge ref_clk);
      #5 cmd.op = STF_OP_NONE;
      ok = (op != STF_OP_QUERY);
      while (!ok && k < 4)
      begin
         ok = (rsp.valid === 1'b1);
         q = rsp.data;
         if (!ok)
         begin
            @(posedge ref_clk);
            #5;
         end
         k++;
      end
      @(posedge ref_clk);
      #5;
   endtask
endmodule // stf_host
